// ==== rtl/xas_pkg.sv ====
package xas_pkg;
  // address map and register reset values of the on-chip window
  localparam logic [15:0] XAS_CAN_BASE    = 16'hf700;
  localparam logic [15:0] XAS_CAN_TOP     = 16'hf7ff;
  localparam logic [15:0] XAS_XRAM_BASE   = 16'hf800;
  localparam logic [7:0]  XAS_WINDOW_PAGE = 8'hf7;
  localparam logic [7:0]  XAS_PAGE_RESET  = 8'h00;
  localparam logic [7:0]  XAS_P2_RESET    = 8'hff;
  localparam logic        XAS_DISABLE_RESET = 1'b1;
  localparam int          XAS_XRAM_AW     = 11;
  localparam logic [10:0] XAS_XRAM_MASK   = 11'h7ff;

  // access sequencer states, one-hot
  typedef enum logic [2:0] {
    XAS_IDLE   = 3'b001,
    XAS_FIRST  = 3'b010,
    XAS_SECOND = 3'b100
  } xas_state_e;
endpackage

// ==== rtl/xas_xram.sv ====
`timescale 1ns/100ps
// xram array: no reset on contents, read data registered
module xas_xram (
  input  wire logic        clk,
  input  wire logic        wr_en,
  input  wire logic [10:0] addr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata
);
  logic [7:0] mem [0:2047];

  // contents survive reset because this process never sees it
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// ==== rtl/xas_steer.sv ====
`timescale 1ns/100ps
// How it works
// R01: paged address is upper page then index
// R02: paged address outside window goes external
// R03: paged window only when page at least f7
// R04: port two write also loads upper page
// R05: software loads page via either register
// R06: xram contents survive reset
// R07: reset in first write cycle aborts write
// R08: pins and strobes follow map bits, access pin
// R09: data pointer below window always external bus
// R10: window access: disable external, else on-chip xram or can space
// R11: visible access shows xram traffic on pins
// R12: paged moves keep port two as io
// R13: global disable set by reset only
// R14: f800-ffff xram, f700-f7ff can space
// R15: upper page resets to zero
module xas_steer (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        page_wr,
  input  wire logic        p2_wr,
  input  wire logic        disable_wr,
  input  wire logic        visible_wr,
  input  wire logic [7:0]  wdata_sfr,
  input  wire logic        external_access_pin,
  input  wire logic        move_start,
  input  wire logic        move_write,
  input  wire logic        move_paged,
  input  wire logic [15:0] data_pointer,
  input  wire logic [7:0]  index_register,
  input  wire logic [7:0]  move_wdata,
  input  wire logic [7:0]  can_rdata,
  output logic      [7:0]  upper_page_register,
  output logic      [7:0]  port_two_latch,
  output logic             xram_global_disable,
  output logic             xram_visible_access,
  output logic             move_busy,
  output logic             move_done,
  output logic      [7:0]  move_rdata,
  output logic             use_internal,
  output logic             can_sel,
  output logic             can_wr,
  output logic             bus_p0,
  output logic             bus_p2,
  output logic      [15:0] pin_addr,
  output logic             rd_active,
  output logic             wr_active
);
  import xas_pkg::*;

  typedef struct packed {
    xas_state_e  state;
    logic [7:0]  page;
    logic [7:0]  p2;
    logic        dis;
    logic        vis;
    logic        wr;
    logic        intl;
    logic        can;
    logic        p0bus;
    logic        p2bus;
    logic        rd_s;
    logic        wr_s;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        done;
    logic [7:0]  rdata;
  } xas_reg_s;

  xas_reg_s r;
  xas_reg_s next_r;
  logic [7:0] xram_rdata;
  logic       xram_we;

  // window decode used for data pointer addressing; paged mode compares the page instead
  function automatic logic in_window(input logic [15:0] a);
    return a >= XAS_CAN_BASE; // [R14]
  endfunction

  function automatic logic is_can(input logic [15:0] a);
    return (a >= XAS_CAN_BASE) && (a <= XAS_CAN_TOP); // [R14]
  endfunction

  // write lands on the edge that ends the first cycle: an async reset before it
  // aborts, while a reset in the second cycle finds the byte already committed
  assign xram_we = (r.state == XAS_FIRST) && r.wr && r.intl && !r.can; // [R07]

  xas_xram u_xram (
    .clk   (clk),
    .wr_en (xram_we),
    .addr  (r.addr[10:0] & XAS_XRAM_MASK),
    .wdata (r.wdata),
    .rdata (xram_rdata)
  );

  always_comb begin
    logic [15:0] a;
    logic        win;
    next_r      = r;
    a           = '0;
    win         = 1'b0;
    next_r.done = 1'b0;
    // sfr writes; port two write also loads page
    if (p2_wr) begin
      next_r.p2   = wdata_sfr; // [R04]
      next_r.page = wdata_sfr; // [R04] [R05]
    end else if (page_wr) begin
      next_r.page = wdata_sfr; // [R04] [R05]
    end
    // disable bit can only be cleared by software
    if (disable_wr && !wdata_sfr[0]) begin
      next_r.dis = 1'b0; // [R13]
    end
    if (visible_wr) begin
      next_r.vis = wdata_sfr[0];
    end
    unique case (r.state)
      XAS_IDLE: begin
        if (move_start) begin
          a = move_paged ? {r.page, index_register} : data_pointer; // [R01]
          win = move_paged ? (r.page >= XAS_WINDOW_PAGE) : in_window(a); // [R03] [R02]
          next_r.addr  = a;
          next_r.wr    = move_write;
          next_r.wdata = move_wdata;
          next_r.intl  = win && !r.dis; // [R10] [R09] [R02]
          next_r.can   = is_can(a);
          // pin use per map bits and access pin
          if (!(win && !r.dis)) begin
            next_r.p0bus = 1'b1; // [R09] [R10]
            next_r.p2bus = !move_paged; // [R12]
            next_r.rd_s  = !move_write;
            next_r.wr_s  = move_write;
          end else begin
            next_r.p0bus = r.vis || !external_access_pin; // [R08] [R11] [R12]
            next_r.p2bus = !move_paged && (r.vis || !external_access_pin); // [R10] [R12]
            next_r.rd_s  = r.vis && !move_write; // [R11]
            next_r.wr_s  = r.vis && move_write; // [R11]
          end
          next_r.state = XAS_FIRST;
        end
      end
      XAS_FIRST: begin
        next_r.state = XAS_SECOND;
      end
      XAS_SECOND: begin
        next_r.state = XAS_IDLE;
        next_r.done  = 1'b1;
        next_r.rdata = r.can ? can_rdata : xram_rdata;
        next_r.p0bus = 1'b0;
        next_r.p2bus = 1'b0;
        next_r.rd_s  = 1'b0;
        next_r.wr_s  = 1'b0;
      end
    endcase
  end

  // reset clears control only; array untouched
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r       <= '0;
      r.state <= XAS_IDLE;
      r.page  <= XAS_PAGE_RESET; // [R15]
      r.p2    <= XAS_P2_RESET;
      r.dis   <= XAS_DISABLE_RESET; // [R13] [R06]
    end else begin
      r <= next_r;
    end
  end

  // outputs; external reads return registered data too
  assign upper_page_register = r.page;
  assign port_two_latch      = r.p2;
  assign xram_global_disable = r.dis;
  assign xram_visible_access = r.vis;
  assign move_busy           = (r.state != XAS_IDLE);
  assign move_done           = r.done;
  assign move_rdata          = r.rdata;
  assign use_internal        = r.intl && (r.state != XAS_IDLE);
  assign can_sel             = r.intl && r.can && (r.state != XAS_IDLE);
  assign can_wr              = can_sel && r.wr && (r.state == XAS_SECOND); // [R07]
  assign bus_p0              = r.p0bus;
  assign bus_p2              = r.p2bus;
  assign pin_addr            = r.addr;
  assign rd_active           = r.rd_s;
  assign wr_active           = r.wr_s;
endmodule

// ==== sim/xas_steer_checker.sv ====
`timescale 1ns/100ps
module xas_steer_checker (
  input wire logic       clk, reset, move_start, move_busy, move_done, move_paged, p2_wr, bus_p2,
  input wire logic       xram_global_disable, xram_visible_access, use_internal, rd_active, wr_active,
  input wire logic [7:0] wdata_sfr, upper_page_register
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // a start is taken only while idle
  wire go = move_start && !move_busy;
  property p_done; go |-> ##3 move_done; endproperty
  a_done: assert property (p_done) else $error("late done");
  property p_busy; go |-> ##1 move_busy [*2] ##1 !move_busy; endproperty
  a_busy: assert property (p_busy) else $error("not two cycles");
  property p_dis; !xram_global_disable |=> !xram_global_disable; endproperty
  a_dis: assert property (p_dis) else $error("disable set again");
  property p_int; use_internal |-> !xram_global_disable; endproperty
  a_int: assert property (p_int) else $error("internal while off");
  property p_pg; p2_wr |=> upper_page_register == $past(wdata_sfr); endproperty
  a_pg: assert property (p_pg) else $error("page not loaded");
  property p_vis; use_internal |-> (rd_active || wr_active) == xram_visible_access; endproperty
  a_vis: assert property (p_vis) else $error("strobe wrong");
  property p_low; go && move_paged && upper_page_register < 8'hf7 |-> ##2 !use_internal; endproperty
  a_low: assert property (p_low) else $error("low page internal");
  property p_io; go && move_paged |-> ##2 !bus_p2 [*2]; endproperty
  a_io: assert property (p_io) else $error("port two on bus");
  c_int: cover property (use_internal && rd_active);
  c_done: cover property (move_done);
  c_p2: cover property (p2_wr);
endmodule
bind xas_steer xas_steer_checker chk (.*);

// ==== sim/xas_can_model.sv ====
`timescale 1ns/100ps
// can space stand-in; unselected it shows a moving pattern so stale data cannot pass
module xas_can_model (
  input  wire logic        clk,
  input  wire logic        can_sel,
  input  wire logic [15:0] pin_addr,
  output logic      [7:0]  can_rdata
);
  logic [7:0] churn = 8'h00;
  always @(posedge clk) churn <= churn + 8'h65;
  assign can_rdata = can_sel ? pin_addr[7:0] ^ 8'h3c : churn;
endmodule

// ==== sim/xas_steer_tb_top.sv ====
`timescale 1ns/100ps
module xas_steer_tb_top;
  import xas_pkg::*;
  logic        clk = '0, reset = '1, page_wr = '0, p2_wr = '0, disable_wr = '0, visible_wr = '0;
  logic        external_access_pin = '0, move_start = '0, move_write = '0, move_paged = '0, s_in, s_b0, s_st;
  logic        move_busy, move_done, use_internal, can_sel, can_wr, bus_p0, bus_p2, rd_active, wr_active;
  logic        xram_global_disable, xram_visible_access;
  logic [7:0]  wdata_sfr = '0, index_register = '0, move_wdata = '0, s_rd;
  logic [7:0]  can_rdata, upper_page_register, port_two_latch, move_rdata;
  logic [15:0] data_pointer = '0, pin_addr, s_pa;
  int          error_cnt = 0, samples_checked = 0;
  always #2.5 clk = ~clk;
  xas_steer dut (.*);
  xas_can_model can (.*);
  task automatic cmp(input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // strobe k: 0 port two, 1 page, 2 disable, 3 visible
  task automatic sfr(input int k, input logic [7:0] d);
    @(negedge clk);
    wdata_sfr = d;
    {p2_wr, page_wr, disable_wr, visible_wr} = 4'h8 >> k;
    @(negedge clk);
    {p2_wr, page_wr, disable_wr, visible_wr} = '0;
  endtask
  // pins caught in the first access cycle, read data once done
  task automatic mv(input logic p, w, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    {move_paged, move_write, data_pointer, index_register, move_wdata, move_start} = {p, w, a, a[7:0], d, 1'h1};
    @(negedge clk);
    move_start = 1'h0;
    {s_in, s_b0, s_st, s_pa} = {use_internal, bus_p0, rd_active | wr_active, pin_addr};
    repeat (2) @(negedge clk);
    cmp(move_done, 1'h1);
    s_rd = move_rdata;
  endtask
  task automatic t_map;
    cmp({upper_page_register, port_two_latch}, {XAS_PAGE_RESET, XAS_P2_RESET});
    mv(0, 1, 16'hf830, 8'h5a);
    cmp({s_in, s_st}, 2'h1);
    sfr(2, 8'h00);
    sfr(2, 8'h01);
    mv(0, 1, 16'hf830, 8'h5a);
    cmp({xram_global_disable, s_in, s_b0, s_st}, 4'h6);
    mv(0, 0, 16'h1234, 8'h00);
    cmp({s_in, s_b0, s_st}, 3'h3);
    mv(0, 0, 16'hf710, 8'h00);
    cmp({s_in, s_rd}, 9'h12c);
    $display("map test end");
  endtask
  task automatic t_page;
    external_access_pin = 1'h1;
    sfr(0, 8'haa);
    cmp(upper_page_register, 8'haa);
    sfr(1, 8'hf8);
    cmp({upper_page_register, port_two_latch}, 16'hf8aa);
    mv(1, 0, 16'h0030, 8'h00);
    cmp(s_pa, 16'hf830);
    cmp({s_in, s_b0, s_st, s_rd}, 11'h45a);
    sfr(0, 8'hf6);
    mv(1, 0, 16'h0030, 8'h00);
    cmp({s_in, s_b0}, 2'h1);
    sfr(3, 8'h01);
    sfr(1, 8'hf7);
    mv(1, 0, 16'h0010, 8'h00);
    cmp({s_in, s_st, s_rd}, 10'h32c);
    $display("page test end");
  endtask
  // reset in the first write cycle keeps the old byte, in the second it commits
  task automatic t_abort;
    for (int k = 0; k < 2; k++) begin
      @(negedge clk);
      {move_paged, move_write, data_pointer, move_wdata, move_start} = {2'h1, 16'hf830, 8'hc3, 1'h1};
      @(negedge clk);
      move_start = 1'h0;
      if (k == 1) @(negedge clk);
      reset = 1'h1;
      @(negedge clk);
      reset = 1'h0;
      sfr(2, 8'h00);
      mv(0, 0, 16'hf830, 8'h00);
      cmp(s_rd, (k == 1) ? 8'hc3 : 8'h5a);
    end
    $display("abort test end");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // about 70 cycles of work; 2000 means a hang
  initial begin
    #10000;
    error_cnt++;
    print_verdict;
  end
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk) reset = 1'h0;
    t_map;
    t_page;
    t_abort;
    print_verdict;
  end
endmodule
